// ===== hdl/diag_rec_pkg.sv
// constants, codes and types for the diagnostic event recorder
// assumes one clock at 10 MHz and the recorder instantiating the event ring
// Overview of operation
// - exception codes 04-07 log as 0Eh/64h-67h
// - request aborted by restart logs 1Eh/0Dh
// - failed record read logs 1Eh/0Eh, keeps value
// - failed record write logs 1Eh/0Fh, keeps value
// - byte count outside 1..1024 logs 1Eh/41h
// - events appended to buffer in occurrence order
// - buffer accepts fault, parameter, request, transmission
// - full buffer drops oldest entry for new
// - buffer reads return newest entry first
// - buffer cleared on power loss, reparameterization
// - event identifier is F1C8h, class, number
// - interrupt enable set by parameterization, reset off
// - interrupt only for broken line, parameter error
// - interrupt data presented on backplane bus
// - four bytes: 25,0C,02,00 or 83,0C,00,00
// - exception codes 01-03 log as 0Eh/61h-63h
package diag_rec_pkg;
	localparam logic [15:0] ID_PREFIX = 16'hf1c8;
	localparam logic [7:0] CLASS_MASTER = 8'h0e;
	localparam logic [7:0] CLASS_BACKPLANE = 8'h1e;
	localparam logic [7:0] NUM_EXC_BASE = 8'h60;
	localparam logic [7:0] NUM_ABORT = 8'h0d;
	localparam logic [7:0] NUM_RD_FAIL = 8'h0e;
	localparam logic [7:0] NUM_WR_FAIL = 8'h0f;
	localparam logic [7:0] NUM_LEN_BAD = 8'h41;
	localparam logic [10:0] COUNT_MIN = 11'h001;
	localparam logic [10:0] COUNT_MAX = 11'h400;
	localparam logic [7:0] EXC_FIRST = 8'h01;
	localparam logic [7:0] EXC_LAST = 8'h07;
	localparam logic [31:0] DIAG_WIRE_BREAK = 32'h25_0c_02_00;
	localparam logic [31:0] DIAG_PARAM_ERR = 32'h83_0c_00_00;
	localparam int DEPTH_DEFAULT = 16;
	typedef enum logic [2:0] {
		IRQ_IDLE = 3'b001,
		IRQ_PEND = 3'b010,
		IRQ_DONE = 3'b100
	} irq_state_t;
endpackage

// ===== hdl/diag_recorder.sv
// diagnostic event recorder: event coding, ring logging, diagnostic interrupt
// assumes event strobes are one-cycle pulses synchronous to SYS_CLK
`timescale 1ns/1ps
module diag_recorder #(
	parameter int DEPTH = diag_rec_pkg::DEPTH_DEFAULT
) (
	input wire logic SYS_CLK,
	input wire logic RST_N,
	input wire logic EXC_REPLY,
	input wire logic [7:0] EXC_CODE,
	input wire logic REQ_ABORT,
	input wire logic RD_FAIL,
	input wire logic WR_FAIL,
	input wire logic [15:0] SERVICE_RETURN_VALUE,
	input wire logic COUNT_CHECK,
	input wire logic [10:0] BYTE_COUNT_PARAMETER,
	input wire logic OTHER_EVENT,
	input wire logic [15:0] OTHER_CODE,
	input wire logic REPARAM,
	input wire logic IRQ_ENABLE_PARAM,
	input wire logic WIRE_BREAK,
	input wire logic PARAM_ERROR,
	input wire logic DIAG_RD,
	input wire logic BUF_RD_START,
	input wire logic BUF_RD_NEXT,
	output logic [31:0] BUF_EVENT_ID,
	output logic BUF_VALID,
	output logic [7:0] BUF_FILL,
	output logic [15:0] SERVICE_ERROR_VARIABLE,
	output logic DIAG_IRQ,
	output logic [7:0] DIAG_DATA,
	output logic GROUP_FAULT_INDICATOR
);
	import diag_rec_pkg::*;
	diag_ring_if ring_bus ();
	logic [15:0] code_d;
	logic log_d;
	logic exc_ok;
	logic count_bad;
	logic irq_en_q;
	irq_state_t irq_q;
	logic [31:0] diag_q;
	logic [1:0] byte_q;
	logic [15:0] ret_q;
	logic [7:0] data_q;
	logic fault_q;

	assign exc_ok = EXC_REPLY && EXC_CODE >= EXC_FIRST && EXC_CODE <= EXC_LAST;
	assign count_bad = COUNT_CHECK && (BYTE_COUNT_PARAMETER < COUNT_MIN || BYTE_COUNT_PARAMETER > COUNT_MAX);

	// one event per cycle; fixed priority when several coincide
	always_comb
	begin
		log_d = 1'b1;
		code_d = OTHER_CODE;
		if (REQ_ABORT)
			code_d = {CLASS_BACKPLANE, NUM_ABORT};
		else if (RD_FAIL)
			code_d = {CLASS_BACKPLANE, NUM_RD_FAIL};
		else if (WR_FAIL)
			code_d = {CLASS_BACKPLANE, NUM_WR_FAIL};
		else if (count_bad)
			code_d = {CLASS_BACKPLANE, NUM_LEN_BAD};
		else if (exc_ok)
			code_d = {CLASS_MASTER, NUM_EXC_BASE + EXC_CODE};
		else if (!OTHER_EVENT)
			log_d = 1'b0;
	end

	assign ring_bus.wr = log_d && !REPARAM;
	assign ring_bus.wr_code = code_d;
	assign ring_bus.clr = REPARAM;
	assign ring_bus.rd_start = BUF_RD_START;
	assign ring_bus.rd_next = BUF_RD_NEXT;

	diag_ring #(
		.DEPTH(DEPTH)
	) u_ring (
		.clk(SYS_CLK),
		.rst_n(RST_N),
		.bus(ring_bus)
	);

	assign BUF_EVENT_ID = {ID_PREFIX, ring_bus.rd_code};
	assign BUF_VALID = ring_bus.rd_valid;
	assign BUF_FILL = ring_bus.fill;

	always_ff @(posedge SYS_CLK or negedge RST_N)
	begin
		if (!RST_N)
			ret_q <= '0;
		else if (RD_FAIL || WR_FAIL)
			ret_q <= SERVICE_RETURN_VALUE;
	end
	assign SERVICE_ERROR_VARIABLE = ret_q;

	always_ff @(posedge SYS_CLK or negedge RST_N)
	begin
		if (!RST_N)
			irq_en_q <= 1'b0;
		else if (REPARAM)
			irq_en_q <= IRQ_ENABLE_PARAM;
	end

	// diagnostic interrupt: latch four bytes, hold request until all are read
	always_ff @(posedge SYS_CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			irq_q <= IRQ_IDLE;
			diag_q <= '0;
			byte_q <= '0;
			data_q <= '0;
		end
		else
		begin
			unique case (irq_q)
				IRQ_IDLE:
				begin
					byte_q <= '0;
					if (irq_en_q && (WIRE_BREAK || PARAM_ERROR))
					begin
						diag_q <= WIRE_BREAK ? DIAG_WIRE_BREAK : DIAG_PARAM_ERR;
						data_q <= WIRE_BREAK ? DIAG_WIRE_BREAK[31:24] : DIAG_PARAM_ERR[31:24];
						irq_q <= IRQ_PEND;
					end
				end
				IRQ_PEND:
					if (DIAG_RD)
					begin
						byte_q <= byte_q + 2'd1;
						// shift the latched word so each read exposes the next byte, zero after the last
						diag_q <= {diag_q[23:0], 8'h00};
						data_q <= diag_q[23:16];
						if (byte_q == 2'd3)
							irq_q <= IRQ_DONE;
					end
				IRQ_DONE:
				begin
					data_q <= '0;
					irq_q <= IRQ_IDLE;
				end
			endcase
		end
	end
	assign DIAG_IRQ = (irq_q == IRQ_PEND);
	assign DIAG_DATA = data_q;

	always_ff @(posedge SYS_CLK or negedge RST_N)
	begin
		if (!RST_N)
			fault_q <= 1'b0;
		else if (DIAG_IRQ)
			fault_q <= 1'b1;
		else if (REPARAM)
			fault_q <= 1'b0;
	end
	assign GROUP_FAULT_INDICATOR = fault_q;

	property p_exc;
		@(posedge SYS_CLK) disable iff (!RST_N)
		(EXC_REPLY && EXC_CODE == 8'h04 && !REQ_ABORT && !RD_FAIL && !WR_FAIL && !count_bad && !REPARAM)
			|-> ring_bus.wr && ring_bus.wr_code == 16'h0e64;
	endproperty
	a_exc: assert property (p_exc) else $error("exception 04 not coded 0e64");
	property p_exc_low;
		@(posedge SYS_CLK) disable iff (!RST_N)
		(EXC_REPLY && EXC_CODE == 8'h01 && !REQ_ABORT && !RD_FAIL && !WR_FAIL && !count_bad && !REPARAM)
			|-> ring_bus.wr_code == 16'h0e61;
	endproperty
	a_exc_low: assert property (p_exc_low) else $error("exception 01 not coded 0e61");
	property p_abort;
		@(posedge SYS_CLK) disable iff (!RST_N)
		(REQ_ABORT && !REPARAM) |-> ring_bus.wr && ring_bus.wr_code == 16'h1e0d;
	endproperty
	a_abort: assert property (p_abort) else $error("abort not coded 1e0d");
	property p_rdfail;
		@(posedge SYS_CLK) disable iff (!RST_N)
		(RD_FAIL && !REQ_ABORT) |=> SERVICE_ERROR_VARIABLE == $past(SERVICE_RETURN_VALUE);
	endproperty
	a_rdfail: assert property (p_rdfail) else $error("read return value not kept");
	property p_wrfail;
		@(posedge SYS_CLK) disable iff (!RST_N)
		(WR_FAIL && !REQ_ABORT && !RD_FAIL && !REPARAM) |-> ring_bus.wr_code == 16'h1e0f;
	endproperty
	a_wrfail: assert property (p_wrfail) else $error("write failure not coded 1e0f");
	property p_len;
		@(posedge SYS_CLK) disable iff (!RST_N)
		(COUNT_CHECK && BYTE_COUNT_PARAMETER == 11'h401 && !REQ_ABORT && !RD_FAIL && !WR_FAIL && !REPARAM)
			|-> ring_bus.wr_code == 16'h1e41;
	endproperty
	a_len: assert property (p_len) else $error("count 1025 not flagged");
	property p_noirq;
		@(posedge SYS_CLK) disable iff (!RST_N)
		(irq_q == IRQ_IDLE && !(irq_en_q && (WIRE_BREAK || PARAM_ERROR))) |=> !DIAG_IRQ;
	endproperty
	a_noirq: assert property (p_noirq) else $error("interrupt without cause");
	property p_bytes;
		@(posedge SYS_CLK) disable iff (!RST_N)
		(irq_q == IRQ_IDLE && irq_en_q && WIRE_BREAK) ##1 DIAG_RD |=> DIAG_DATA == 8'h0c;
	endproperty
	a_bytes: assert property (p_bytes) else $error("wire break byte 1 wrong");
	property p_hold;
		@(posedge SYS_CLK) disable iff (!RST_N)
		(DIAG_IRQ && byte_q != 2'd3) |=> DIAG_IRQ;
	endproperty
	a_hold: assert property (p_hold) else $error("interrupt dropped early");
endmodule

// ===== hdl/diag_ring.sv
// overwrite-oldest event ring read newest first
// assumes the owner sends at most one write per clock
`timescale 1ns/1ps
module diag_ring #(
	parameter int DEPTH = 16
) (
	input wire logic clk,
	input wire logic rst_n,
	diag_ring_if.ring bus
);
	import diag_rec_pkg::*;
	localparam int AW = $clog2(DEPTH);
	logic [15:0] mem [DEPTH];
	logic [AW-1:0] head_q;
	logic [AW:0] count_q;
	logic [AW-1:0] rp_q;
	logic [AW:0] left_q;
	logic [15:0] rd_code_q;

	always_ff @(posedge clk)
	begin
		if (bus.wr)
			mem[head_q] <= bus.wr_code;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			head_q <= '0;
			count_q <= '0;
		end
		else if (bus.clr)
		begin
			head_q <= '0;
			count_q <= '0;
		end
		else if (bus.wr)
		begin
			head_q <= (head_q == AW'(DEPTH - 1)) ? '0 : head_q + 1'b1;
			if (count_q != (AW+1)'(DEPTH))
				count_q <= count_q + 1'b1;
		end
	end

	// read cursor walks from the newest entry toward older ones
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rp_q <= '0;
			left_q <= '0;
			rd_code_q <= '0;
		end
		else if (bus.clr || bus.wr)
			left_q <= '0;
		else if (bus.rd_start && count_q != '0)
		begin
			rp_q <= (head_q == '0) ? AW'(DEPTH - 1) : head_q - 1'b1;
			rd_code_q <= mem[(head_q == '0) ? AW'(DEPTH - 1) : head_q - 1'b1];
			left_q <= count_q;
		end
		else if (bus.rd_next && left_q != '0)
		begin
			rp_q <= (rp_q == '0) ? AW'(DEPTH - 1) : rp_q - 1'b1;
			rd_code_q <= mem[(rp_q == '0) ? AW'(DEPTH - 1) : rp_q - 1'b1];
			left_q <= left_q - 1'b1;
		end
	end

	assign bus.rd_code = rd_code_q;
	assign bus.rd_valid = (left_q != '0);
	assign bus.fill = 8'(count_q);

	property p_wrap;
		@(posedge clk) disable iff (!rst_n)
		(bus.wr && !bus.clr && count_q == (AW+1)'(DEPTH)) |=> count_q == (AW+1)'(DEPTH);
	endproperty
	a_wrap: assert property (p_wrap) else $error("full ring count changed on write");
	property p_newest;
		@(posedge clk) disable iff (!rst_n)
		(bus.wr && !bus.clr) ##1 (bus.rd_start && !bus.wr && !bus.clr) |=> rd_code_q == $past(bus.wr_code, 2);
	endproperty
	a_newest: assert property (p_newest) else $error("first read not newest entry");
	property p_clear;
		@(posedge clk) disable iff (!rst_n)
		bus.clr |=> count_q == '0 && !bus.rd_valid;
	endproperty
	a_clear: assert property (p_clear) else $error("ring not cleared");
endmodule

// ===== hdl/diag_ring_if.sv
// write/read carrier between the recorder and its event ring
// assumes one clock domain shared by both ends
`timescale 1ns/1ps
interface diag_ring_if;
	logic wr;
	logic [15:0] wr_code;
	logic clr;
	logic rd_start;
	logic rd_next;
	logic [15:0] rd_code;
	logic rd_valid;
	logic [7:0] fill;
	modport owner (output wr, wr_code, clr, rd_start, rd_next, input rd_code, rd_valid, fill);
	modport ring (input wr, wr_code, clr, rd_start, rd_next, output rd_code, rd_valid, fill);
endinterface

// ===== verification/diag_recorder_tb.sv
// self-checking bench for the diagnostic event recorder
// assumes the recorder built with DEPTH 4 and a host model reading interrupts
`timescale 1ns/1ps
module diag_recorder_tb;
	import diag_rec_pkg::*;
	logic sys_clk, rst_n, ien, dr, sn, sx, vld, irq, gf;
	logic [8:0] stb;
	logic [7:0] exc, fill, dd;
	logic [15:0] rv, oc, sev;
	logic [10:0] bc;
	logic [31:0] id, word;
	int reads, miscompares, num_checks;
	diag_recorder #(.DEPTH(4)) DUT (
		.SYS_CLK(sys_clk), .RST_N(rst_n), .EXC_REPLY(stb[4]), .EXC_CODE(exc),
		.REQ_ABORT(stb[0]), .RD_FAIL(stb[1]), .WR_FAIL(stb[2]), .SERVICE_RETURN_VALUE(rv),
		.COUNT_CHECK(stb[3]), .BYTE_COUNT_PARAMETER(bc), .OTHER_EVENT(stb[5]), .OTHER_CODE(oc),
		.REPARAM(stb[6]), .IRQ_ENABLE_PARAM(ien), .WIRE_BREAK(stb[7]), .PARAM_ERROR(stb[8]),
		.DIAG_RD(dr), .BUF_RD_START(sn), .BUF_RD_NEXT(sx), .BUF_EVENT_ID(id), .BUF_VALID(vld),
		.BUF_FILL(fill), .SERVICE_ERROR_VARIABLE(sev), .DIAG_IRQ(irq), .DIAG_DATA(dd),
		.GROUP_FAULT_INDICATOR(gf));
	host_cpu_model host (.clk(sys_clk), .irq(irq), .data(dd), .rd(dr), .word(word), .reads(reads));
	initial
	begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end
	task tick;
		@(negedge sys_clk);
	endtask
	task check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// one-hot strobe for one cycle; held across calls for back-to-back events
	task fire(input int b);
		stb = 9'h001 << b;
		tick;
	endtask
	task idle;
		stb = '0;
		tick;
	endtask
	task read_pass(input logic [15:0] c [4], input int n);
		check({24'h0, fill}, n);
		sn = 1'b1;
		tick;
		sn = 1'b0;
		for (int i = 0; i < n; i++)
		begin
			check(id, {ID_PREFIX, c[i]});
			check({31'h0, vld}, 1);
			sx = 1'b1;
			tick;
		end
		sx = 1'b0;
		check({31'h0, vld}, 0);
	endtask
	task wait_reads(input int n);
		for (int i = 0; i < 60 && !(reads == n && irq === 1'b0); i++) tick;
		check(reads, n);
	endtask
	task t_exc;
		for (int k = 1; k < 8; k++)
		begin
			exc = 8'(k);
			fire(4);
		end
		idle;
		read_pass('{16'h0e67, 16'h0e66, 16'h0e65, 16'h0e64}, 4);
		fire(6);
		idle;
		check({24'h0, fill}, 0);
		for (int k = 1; k < 4; k++)
		begin
			exc = 8'(k);
			fire(4);
		end
		exc = 8'h08;
		fire(4);
		oc = 16'h1234;
		fire(5);
		idle;
		read_pass('{16'h1234, 16'h0e63, 16'h0e62, 16'h0e61}, 4);
		$display("t_exc done");
	endtask
	task t_host;
		fire(6);
		rv = 16'h8091;
		fire(1);
		stb = '0;
		read_pass('{16'h1e0e, 16'h0000, 16'h0000, 16'h0000}, 1);
		check(sev, 16'h8091);
		fire(0);
		rv = 16'h80a2;
		fire(2);
		bc = 11'h000;
		fire(3);
		bc = 11'h400;
		fire(3);
		bc = 11'h401;
		fire(3);
		idle;
		check(sev, 16'h80a2);
		read_pass('{16'h1e41, 16'h1e41, 16'h1e0f, 16'h1e0d}, 4);
		$display("t_host done");
	endtask
	task t_irq;
		fire(7);
		idle;
		repeat (3) tick;
		check({30'h0, irq, gf}, 0);
		ien = 1'b1;
		fire(6);
		fire(0);
		idle;
		tick;
		check({31'h0, irq}, 0);
		fire(7);
		idle;
		repeat (4) tick;
		check({31'h0, irq}, 1);
		wait_reads(1);
		check(word, DIAG_WIRE_BREAK);
		check({31'h0, gf}, 1);
		fire(8);
		idle;
		wait_reads(2);
		check(word, DIAG_PARAM_ERR);
		rst_n = 1'b0;
		tick;
		rst_n = 1'b1;
		check({23'h0, gf, fill}, 0);
		fire(7);
		idle;
		tick;
		check({31'h0, irq}, 0);
		$display("t_irq done");
	endtask
	task end_sim;
		$display("checks %0d, mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial
	begin
		repeat (3000) @(posedge sys_clk);
		miscompares++;
		end_sim;
	end
	initial
	begin
		rst_n = 1'b0;
		{ien, sn, sx, stb, exc, rv, oc, bc} = '0;
		repeat (3) @(posedge sys_clk);
		tick;
		rst_n = 1'b1;
		check(id, {ID_PREFIX, 16'h0000});
		check({24'h0, fill}, 0);
		tick;
		t_exc;
		t_host;
		t_irq;
		end_sim;
	end
endmodule

// ===== verification/host_cpu_model.sv
// host cpu model: on a diagnostic interrupt reads the four diagnostic bytes
// assumes inputs sampled and outputs driven at the falling clock edge
`timescale 1ns/1ps
module host_cpu_model (
	input wire logic clk,
	input wire logic irq,
	input wire logic [7:0] data,
	output logic rd,
	output logic [31:0] word,
	output int reads
);
	initial
	begin
		rd = 1'b0;
		word = '0;
		reads = 0;
		forever
		begin
			@(negedge clk);
			if (irq === 1'b1)
			begin
				for (int i = 0; i < 4; i++)
				begin
					word = {word[23:0], data};
					rd = 1'b1;
					@(negedge clk);
					rd = 1'b0;
					@(negedge clk);
				end
				reads = reads + 1;
				// no new interrupt expected until the request has dropped
				while (irq === 1'b1) @(negedge clk);
			end
		end
	end
endmodule
